//--- hw/ebes_top.sv
// expansion bus error supervisor: watches the configured expansion modules,
// raises the bus error, retries silent modules and holds or zeroes their outputs.
// assumes answer and embedded input pins are asynchronous to i_mclk.
`timescale 1ns/1ps

// Overview of operation
// - error when required configured module stays silent
// - check at startup and while running
// - runtime error: bit, status word, flashing led
// - keep retrying silent modules while error active
// - newer family: hold, then zero when one shared ten-second timer, started by the first held module, expires
// - older family: hold until power or init
// - logic and embedded I/O keep running
// - restored newer-family modules return to application control; older ones stay held until init
// - optional absent modules are no error
// - config mismatch stops expansion, embedded continues
module ebes_top
    import ebes_pkg::*;
#(
    parameter int N_MOD = MOD_MAX,
    parameter int HOLD_CNT = HOLD_CYCLES,
    parameter int RETRY_CNT = RETRY_CYCLES,
    parameter int FLASH_CNT = FLASH_CYCLES,
    parameter int EMB_W = 16
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    input wire logic [N_MOD-1:0] i_mod_answer,
    input wire logic [EMB_W-1:0] i_emb_in,
    output logic [EMB_W-1:0] o_emb_out,
    output logic [N_MOD-1:0] o_retry_req,
    output logic o_exp_out_valid,
    output logic [2:0] o_exp_out_idx,
    output logic [OUT_WIDTH-1:0] o_exp_out_data,
    output logic o_err_led,
    output logic o_expansion_bus_error_bit
);

    localparam logic [31:0] HOLD_LAST = 32'(HOLD_CNT - 1);
    localparam logic [31:0] RETRY_LAST = 32'(RETRY_CNT - 1);
    localparam logic [31:0] FLASH_LAST = 32'(FLASH_CNT - 1);
    localparam logic [2:0] IDX_LAST = 3'(N_MOD - 1);

    // ==========================================================
    // input synchronisers
    logic [N_MOD-1:0] ans_meta_q, ans_q;
    logic [EMB_W-1:0] emb_meta_q, emb_q;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ans_meta_q <= '0;
            ans_q <= '0;
            emb_meta_q <= '0;
            emb_q <= '0;
        end else begin
            ans_meta_q <= i_mod_answer;
            ans_q <= ans_meta_q;
            emb_meta_q <= i_emb_in;
            emb_q <= emb_meta_q;
        end
    end

    // ==========================================================
    // configuration and control registers
    logic [N_MOD-1:0] present_q, optional_q, family_q;
    logic run_q;
    logic [IRQ_W-1:0] irq_mask_q, irq_stat_q, irq_stat_d;
    logic [EMB_W-1:0] emb_out_q;
    logic start_err_q;
    logic [31:0] rdata_q;

    wire wr_present = i_wr && (i_addr == REG_CFG_PRESENT);
    wire wr_optional = i_wr && (i_addr == REG_CFG_OPTIONAL);
    wire wr_family = i_wr && (i_addr == REG_CFG_FAMILY);
    wire wr_ctrl = i_wr && (i_addr == REG_CTRL);
    wire wr_mask = i_wr && (i_addr == REG_IRQ_MASK);
    wire wr_emb = i_wr && (i_addr == REG_EMB_OUT);
    wire wr_exp = i_wr && (i_addr >= REG_EXP_OUT_BASE) && (i_addr < REG_EXP_OUT_BASE + 8'(4 * N_MOD));
    wire [2:0] wr_exp_idx = 3'((i_addr - REG_EXP_OUT_BASE) >> 2);
    wire init_cmd = wr_ctrl && i_wdata[CTRL_INIT_BIT];
    wire rd_irq = i_rd && (i_addr == REG_IRQ_STATUS);

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            present_q <= '0;
            optional_q <= '0;
            family_q <= '0;
            run_q <= 1'b0;
            irq_mask_q <= RST_IRQ_MASK;
            emb_out_q <= '0;
        end else begin
            if (wr_present) present_q <= i_wdata[N_MOD-1:0];
            if (wr_optional) optional_q <= i_wdata[N_MOD-1:0];
            if (wr_family) family_q <= i_wdata[N_MOD-1:0];
            if (wr_ctrl) run_q <= i_wdata[CTRL_RUN_BIT];
            if (wr_mask) irq_mask_q <= i_wdata[IRQ_W-1:0];
            if (wr_emb) emb_out_q <= i_wdata[EMB_W-1:0];
        end
    end

    // embedded outputs never depend on expansion bus health
    assign o_emb_out = emb_out_q;

    // ==========================================================
    // failure detection
    // optional modules are masked out, so their absence is silent
    wire [N_MOD-1:0] required = present_q & ~optional_q;
    wire [N_MOD-1:0] failed = required & ~ans_q;
    wire bus_err = |failed;
    // an answering module that the configuration does not know
    wire mismatch = |(ans_q & ~present_q);

    logic bus_err_q, zero_any_q;
    ebes_phase_t phase_q, phase_d;

    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            EBES_STARTUP: begin
                if (run_q) phase_d = bus_err ? EBES_FAULT : EBES_RUN;
            end
            EBES_RUN: begin
                if (!run_q) phase_d = EBES_STARTUP;
                else if (bus_err) phase_d = EBES_FAULT;
            end
            EBES_FAULT: begin
                if (!run_q) phase_d = EBES_STARTUP;
                else if (!bus_err) phase_d = EBES_RUN;
            end
            default: phase_d = EBES_STARTUP;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase_q <= EBES_STARTUP;
            bus_err_q <= 1'b0;
            start_err_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            bus_err_q <= bus_err;
            // a failure seen while stopped in the same cycle as the init command still sets the flag
            if (!run_q && bus_err) start_err_q <= 1'b1;
            else if (init_cmd) start_err_q <= 1'b0;
        end
    end

    assign o_expansion_bus_error_bit = bus_err_q;

    // ==========================================================
    // retry pacing: one request per silent required module per retry tick
    logic [31:0] retry_cnt_q;
    logic [N_MOD-1:0] retry_q;
    wire retry_tick = (retry_cnt_q == RETRY_LAST);

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            retry_cnt_q <= '0;
            retry_q <= '0;
        end else begin
            retry_cnt_q <= retry_tick ? 32'h0000_0000 : retry_cnt_q + 32'h0000_0001;
            retry_q <= retry_tick ? failed : '0;
        end
    end

    assign o_retry_req = retry_q;

    // ==========================================================
    // per-module hold and zero state
    logic [N_MOD-1:0] hold_q, zero_q;
    logic [31:0] hold_cnt_q;
    wire [N_MOD-1:0] newer_waiting = hold_q & family_q & ~zero_q;
    wire hold_expired = (hold_cnt_q == HOLD_LAST);

    // single timer: restarts whenever no newer-family module is waiting
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hold_cnt_q <= '0;
        end else if (init_cmd || !(|newer_waiting) || hold_expired) begin
            hold_cnt_q <= '0;
        end else begin
            hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_MOD; g++) begin : g_mod
            always_ff @(posedge i_mclk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    hold_q[g] <= 1'b0;
                    zero_q[g] <= 1'b0;
                end else if (init_cmd) begin
                    hold_q[g] <= 1'b0;
                    zero_q[g] <= 1'b0;
                end else if (failed[g]) begin
                    hold_q[g] <= 1'b1;
                    if (family_q[g] && hold_q[g] && hold_expired) zero_q[g] <= 1'b1;
                end else if (family_q[g]) begin
                    hold_q[g] <= 1'b0;
                    zero_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================================
    // expansion output exchange: scans every module, one per cycle
    logic [2:0] scan_q, scan1_q;
    logic valid_q;
    logic [2:0] idx_q;
    logic [OUT_WIDTH-1:0] data_q;
    logic [OUT_WIDTH-1:0] mem_rdata;

    // held modules ignore application writes, keeping their last values
    wire exp_we = wr_exp && !hold_q[wr_exp_idx];

    ebes_mem #(
        .DEPTH(N_MOD),
        .WIDTH(OUT_WIDTH),
        .AW(3)
    ) u_mem (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_we(exp_we),
        .i_waddr(wr_exp_idx),
        .i_wdata(i_wdata[OUT_WIDTH-1:0]),
        .i_raddr(scan_q),
        .o_rdata(mem_rdata)
    );

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scan_q <= '0;
            scan1_q <= '0;
            valid_q <= 1'b0;
            idx_q <= '0;
            data_q <= '0;
        end else begin
            scan_q <= (scan_q == IDX_LAST) ? 3'h0 : scan_q + 3'h1;
            scan1_q <= scan_q;
            idx_q <= scan1_q;
            // mismatch halts expansion traffic only
            valid_q <= run_q && !mismatch && present_q[scan1_q];
            data_q <= zero_q[scan1_q] ? '0 : mem_rdata;
        end
    end

    assign o_exp_out_valid = valid_q;
    assign o_exp_out_idx = idx_q;
    assign o_exp_out_data = data_q;

    // ==========================================================
    // error led flashes only while a runtime bus error stands
    logic [31:0] flash_cnt_q;
    logic led_q;
    wire flash_tick = (flash_cnt_q == FLASH_LAST);

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flash_cnt_q <= '0;
            led_q <= 1'b0;
        end else if (phase_q != EBES_FAULT) begin
            flash_cnt_q <= '0;
            led_q <= 1'b0;
        end else begin
            flash_cnt_q <= flash_tick ? 32'h0000_0000 : flash_cnt_q + 32'h0000_0001;
            if (flash_tick) led_q <= ~led_q;
        end
    end

    assign o_err_led = led_q;

    // ==========================================================
    // interrupt status: set wins over the read clear
    logic mismatch_q, zero_any_d;
    assign zero_any_d = |zero_q;
    wire [IRQ_W-1:0] irq_evt = {mismatch && !mismatch_q, zero_any_d && !zero_any_q,
                                !bus_err && bus_err_q, bus_err && !bus_err_q};

    assign irq_stat_d = (rd_irq ? {IRQ_W{1'b0}} : irq_stat_q) | irq_evt;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_stat_q <= '0;
            mismatch_q <= 1'b0;
            zero_any_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            mismatch_q <= mismatch;
            zero_any_q <= zero_any_d;
        end
    end

    assign o_irq = |(irq_stat_q & irq_mask_q);

    // ==========================================================
    // read path: data stands for exactly the cycle after the strobe
    logic [31:0] rd_mux;
    wire [31:0] status_word = {27'h0, |zero_q, mismatch_q, run_q, start_err_q, bus_err_q};

    always_comb begin
        rd_mux = RST_ZERO;
        case (i_addr)
            REG_CFG_PRESENT: rd_mux = 32'(present_q);
            REG_CFG_OPTIONAL: rd_mux = 32'(optional_q);
            REG_CFG_FAMILY: rd_mux = 32'(family_q);
            REG_CTRL: rd_mux = {31'h0, run_q};
            REG_STATUS: rd_mux = status_word;
            REG_MOD_STATUS: rd_mux = 32'(failed);
            REG_IRQ_STATUS: rd_mux = 32'(irq_stat_q);
            REG_IRQ_MASK: rd_mux = 32'(irq_mask_q);
            REG_EMB_OUT: rd_mux = 32'(emb_out_q);
            REG_EMB_IN: rd_mux = 32'(emb_q);
            REG_HOLD_MAP: rd_mux = {16'h0, 1'b0, 7'(zero_q), 1'b0, 7'(hold_q)};
            default: rd_mux = RST_ZERO;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= i_rd ? rd_mux : RST_ZERO;
        end
    end

    assign o_rdata = rdata_q;

endmodule // ebes_top

//--- hw/ebes_pkg.sv
// package for the expansion bus error supervisor: register map, field
// positions, reset values and timing counts.
// assumes a 20 MHz system clock and a 32-bit plain register port.
package ebes_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_HZ = 20000000;
    localparam int HOLD_TIME_MS = 10000;
    localparam int HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);
    localparam int RETRY_TIME_US = 1000;
    localparam int RETRY_CYCLES = RETRY_TIME_US * (CLK_HZ / 1000000);
    localparam int FLASH_TIME_MS = 250;
    localparam int FLASH_CYCLES = FLASH_TIME_MS * (CLK_HZ / 1000);

    // ==========================================================
    // sizes
    localparam int MOD_MAX = 7;
    localparam int OUT_WIDTH = 16;
    localparam int ADDR_W = 8;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] REG_CFG_PRESENT = 8'h00;
    localparam logic [7:0] REG_CFG_OPTIONAL = 8'h04;
    localparam logic [7:0] REG_CFG_FAMILY = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_MOD_STATUS = 8'h14;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h18;
    localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
    localparam logic [7:0] REG_EMB_OUT = 8'h20;
    localparam logic [7:0] REG_EMB_IN = 8'h24;
    localparam logic [7:0] REG_HOLD_MAP = 8'h28;
    localparam logic [7:0] REG_EXP_OUT_BASE = 8'h40;

    // ==========================================================
    // field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_INIT_BIT = 1;
    localparam int ST_BUS_ERR_BIT = 0;
    localparam int ST_START_ERR_BIT = 1;
    localparam int ST_RUN_BIT = 2;
    localparam int ST_MISMATCH_BIT = 3;
    localparam int ST_ZEROED_BIT = 4;
    localparam int IRQ_ERR_SET_BIT = 0;
    localparam int IRQ_ERR_CLR_BIT = 1;
    localparam int IRQ_ZERO_BIT = 2;
    localparam int IRQ_MISMATCH_BIT = 3;
    localparam int IRQ_W = 4;

    // ==========================================================
    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;

    // ==========================================================
    // supervisor phase
    typedef enum logic [1:0] {
        EBES_STARTUP = 2'b00,
        EBES_RUN = 2'b01,
        EBES_FAULT = 2'b10
    } ebes_phase_t;

endpackage

//--- hw/ebes_mem.sv
// small memory for the application output word of each expansion module.
// assumes one write port and one read port on the same clock; read data registered.
`timescale 1ns/1ps

module ebes_mem #(
    parameter int DEPTH = 7,
    parameter int WIDTH = 16,
    parameter int AW = 3
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);

    logic [WIDTH-1:0] mem_q [DEPTH];

    // ==========================================================
    // storage; cleared at reset so outputs start at zero
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int k = 0; k < DEPTH; k++) begin
                mem_q[k] <= '0;
            end
        end else if (i_we && (int'(i_waddr) < DEPTH)) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= '0;
        end else if (int'(i_raddr) < DEPTH) begin
            o_rdata <= mem_q[i_raddr];
        end else begin
            o_rdata <= '0;
        end
    end

endmodule // ebes_mem

//--- testbench/ebes_exp_chain.sv
// behavioural chain of expansion modules standing on the far side of the supervisor.
// assumes the bench chooses which modules are attached and whether they answer promptly.
`timescale 1ns/1ps
module ebes_exp_chain #(
    parameter int N = 7
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [N-1:0] i_attached,
    input wire logic i_slow,
    input wire logic [N-1:0] i_retry_req,
    output logic [N-1:0] o_answer
);
    // ==========
    // answer lines
    // a detached module is silent; in slow mode a reattached one stays silent
    // until a retry reaches it, so recovery leans on the retry pulses
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_answer <= '0;
        end else begin
            o_answer <= i_attached & (o_answer | ~{N{i_slow}} | i_retry_req);
        end
    end
endmodule // ebes_exp_chain

//--- testbench/ebes_top_sva.sv
// checker for the supervisor, seeing only the top ports.
// assumes the configuration is written over the plain register port.
`timescale 1ns/1ps
module ebes_top_sva
    import ebes_pkg::*;
#(
    parameter int N_MOD = MOD_MAX,
    parameter int HOLD_CNT = HOLD_CYCLES,
    parameter int RETRY_CNT = RETRY_CYCLES,
    parameter int FLASH_CNT = FLASH_CYCLES,
    parameter int EMB_W = 16
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_irq,
    input wire logic [N_MOD-1:0] i_mod_answer,
    input wire logic [EMB_W-1:0] i_emb_in,
    input wire logic [EMB_W-1:0] o_emb_out,
    input wire logic [N_MOD-1:0] o_retry_req,
    input wire logic o_exp_out_valid,
    input wire logic [2:0] o_exp_out_idx,
    input wire logic [OUT_WIDTH-1:0] o_exp_out_data,
    input wire logic o_err_led,
    input wire logic o_expansion_bus_error_bit
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);
    // ==========
    // shadow configuration and gap counters
    logic [N_MOD-1:0] pres_q, opt_q;
    logic [IRQ_W-1:0] mask_q;
    logic run_q;
    int retry_gap_q, led_gap_q;
    wire logic req_fail = |(pres_q & ~opt_q & ~i_mod_answer);
    wire logic fault = run_q && o_expansion_bus_error_bit;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pres_q <= '0;
            opt_q <= '0;
            mask_q <= '0;
            run_q <= 1'b0;
        end else if (i_wr) begin
            if (i_addr == REG_CFG_PRESENT) pres_q <= i_wdata[N_MOD-1:0];
            if (i_addr == REG_CFG_OPTIONAL) opt_q <= i_wdata[N_MOD-1:0];
            if (i_addr == REG_IRQ_MASK) mask_q <= i_wdata[IRQ_W-1:0];
            if (i_addr == REG_CTRL) run_q <= i_wdata[CTRL_RUN_BIT];
        end
    end
    // a stuck retry timer or flash divider shows up as a run-away count
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            retry_gap_q <= 0;
            led_gap_q <= 0;
        end else begin
            retry_gap_q <= (o_expansion_bus_error_bit && o_retry_req == '0) ? retry_gap_q + 1 : 0;
            led_gap_q <= (fault && o_err_led == $past(o_err_led)) ? led_gap_q + 1 : 0;
        end
    end
    // ==========
    // assertions
    AST_ERR_SET: assert property (req_fail [*5] |-> o_expansion_bus_error_bit)
        else $error("bus error bit low while a required module is silent");
    AST_ERR_CLR: assert property ((!req_fail) [*5] |-> !o_expansion_bus_error_bit)
        else $error("bus error bit high while all required modules answer");
    AST_RETRY_PULSE: assert property (|o_retry_req |=> o_retry_req == '0)
        else $error("retry request longer than one cycle");
    AST_RETRY_GAP: assert property (retry_gap_q <= RETRY_CNT + 3)
        else $error("no retry while the bus error stays active");
    AST_LED_OFF: assert property ((!o_expansion_bus_error_bit) [*3] |-> !o_err_led)
        else $error("error led lit without a bus error");
    AST_LED_FLASH: assert property (led_gap_q <= FLASH_CNT + 3)
        else $error("error led not flashing during a runtime bus error");
    AST_IRQ_MASKED: assert property ((mask_q == '0) [*2] |-> !o_irq)
        else $error("interrupt raised with every source masked");
    AST_EMB_OUT: assert property (i_wr && i_addr == REG_EMB_OUT |=> o_emb_out == $past(i_wdata[EMB_W-1:0]))
        else $error("embedded outputs did not follow the application write");
    AST_EXP_IDLE: assert property ((!run_q) [*5] |-> !o_exp_out_valid)
        else $error("expansion outputs sent while logic is stopped");
    COV_ERR: cover property ($rose(o_expansion_bus_error_bit));
    COV_LED: cover property ($rose(o_err_led));
    COV_ZERO: cover property (o_exp_out_valid && o_exp_out_data == '0);
endmodule // ebes_top_sva

bind ebes_top ebes_top_sva #(.N_MOD(N_MOD), .HOLD_CNT(HOLD_CNT), .RETRY_CNT(RETRY_CNT), .FLASH_CNT(FLASH_CNT),
    .EMB_W(EMB_W)) u_sva (.i_mclk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .i_mod_answer,
    .i_emb_in, .o_emb_out, .o_retry_req, .o_exp_out_valid, .o_exp_out_idx, .o_exp_out_data, .o_err_led,
    .o_expansion_bus_error_bit);

//--- testbench/ebes_tb_top.sv
// self-checking bench for the supervisor with a model chain of expansion modules.
// assumes short hold, retry and flash counts so the run stays brief.
`timescale 1ns/1ps
module ebes_tb_top
    import ebes_pkg::*;
;
    logic i_mclk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [31:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] i_emb_in = 16'hC3C3;
    logic [6:0] attached = 7'h01;
    logic slow = 1'b0;
    logic [31:0] o_rdata;
    logic o_irq, o_exp_out_valid, o_err_led, o_expansion_bus_error_bit;
    logic [6:0] i_mod_answer, o_retry_req;
    logic [15:0] o_emb_out, o_exp_out_data;
    logic [2:0] o_exp_out_idx;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    always #25 i_mclk = ~i_mclk;
    ebes_top #(.HOLD_CNT(50), .RETRY_CNT(8), .FLASH_CNT(4)) uut (.i_mclk, .i_reset_n, .i_addr, .i_wdata, .i_wr,
        .i_rd, .o_rdata, .o_irq, .i_mod_answer, .i_emb_in, .o_emb_out, .o_retry_req, .o_exp_out_valid,
        .o_exp_out_idx, .o_exp_out_data, .o_err_led, .o_expansion_bus_error_bit);
    ebes_exp_chain chain (.i_mclk, .i_reset_n, .i_attached(attached), .i_slow(slow), .i_retry_req(o_retry_req),
        .o_answer(i_mod_answer));
    // ==========
    // shared tasks
    function automatic logic [31:0] f1(input logic x);
        return {31'h0, x};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        // one idle edge keeps a following write from touching the strobe in this step
        @(posedge i_mclk);
    endtask
    // read data stand only in the cycle after the strobe, sampled at its closing edge
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(posedge i_mclk);
        check(o_rdata & m, e, "read data");
    endtask
    // a new word needs a full scan before slot 0 carries it
    task automatic see(input logic ev, input logic [15:0] ed);
        int n;
        n = 0;
        cyc(10);
        while (o_exp_out_idx !== 3'h0 && n < 20) begin
            @(posedge i_mclk);
            n++;
        end
        check({29'h0, o_exp_out_idx}, 32'h0, "stream index");
        check(f1(o_exp_out_valid), f1(ev), "stream valid");
        if (ev) check({16'h0, o_exp_out_data}, {16'h0, ed}, "stream data");
    endtask
    // ==========
    // scenarios
    task automatic t_regs();
        rd(REG_STATUS, 32'h0, 32'hFFFFFFFF);
        rd(REG_IRQ_MASK, 32'h0, 32'hFFFFFFFF);
        rd(8'hFC, 32'h0, 32'hFFFFFFFF);
        $display("test regs done");
    endtask
    task automatic t_startup();
        wr(REG_CFG_OPTIONAL, 32'h2);
        wr(REG_CFG_PRESENT, 32'h3);
        cyc(6);
        check(f1(o_expansion_bus_error_bit), 32'h0, "optional module absent");
        attached <= 7'h00;
        cyc(6);
        rd(REG_STATUS, 32'h3, 32'h7);
        rd(REG_MOD_STATUS, 32'h1, 32'hFFFFFFFF);
        check(f1(o_err_led), 32'h0, "led while stopped");
        attached <= 7'h01;
        cyc(6);
        rd(REG_STATUS, 32'h2, 32'h3);
        wr(REG_CTRL, 32'h2);
        rd(REG_STATUS, 32'h0, 32'h3);
        $display("test startup done");
    endtask
    task automatic t_runtime();
        int flips;
        int tries;
        logic prev;
        flips = 0;
        tries = 0;
        prev = 1'b0;
        wr(REG_IRQ_MASK, 32'h1);
        wr(REG_CFG_FAMILY, 32'h1);
        wr(REG_EXP_OUT_BASE, 32'hA5A5);
        wr(REG_CTRL, 32'h1);
        see(1'b1, 16'hA5A5);
        slow <= 1'b1;
        attached <= 7'h00;
        cyc(5);
        check(f1(o_irq), 32'h1, "interrupt on bus error");
        repeat (24) begin
            @(posedge i_mclk);
            flips += int'(o_err_led !== prev);
            tries += int'(o_retry_req[0] === 1'b1);
            prev = o_err_led;
        end
        check(f1(flips >= 4), 32'h1, "led flashing");
        check(f1(tries >= 2), 32'h1, "retry pulses");
        wr(REG_EMB_OUT, 32'h5A5A);
        cyc(1);
        check({16'h0, o_emb_out}, 32'h5A5A, "embedded outputs");
        rd(REG_EMB_IN, 32'hC3C3, 32'hFFFF);
        rd(REG_IRQ_STATUS, 32'h1, 32'h1);
        cyc(1);
        check(f1(o_irq), 32'h0, "interrupt after read");
        cyc(50);
        rd(REG_STATUS, 32'h10, 32'h10);
        see(1'b1, 16'h0);
        attached <= 7'h01;
        cyc(16);
        check(f1(o_expansion_bus_error_bit), 32'h0, "error after restore");
        check(f1(o_err_led), 32'h0, "led after restore");
        wr(REG_EXP_OUT_BASE, 32'h1111);
        see(1'b1, 16'h1111);
        slow <= 1'b0;
        $display("test runtime done");
    endtask
    task automatic t_older();
        wr(REG_CFG_FAMILY, 32'h0);
        wr(REG_EXP_OUT_BASE, 32'h1234);
        see(1'b1, 16'h1234);
        attached <= 7'h00;
        cyc(60);
        see(1'b1, 16'h1234);
        attached <= 7'h01;
        cyc(8);
        wr(REG_EXP_OUT_BASE, 32'h4321);
        see(1'b1, 16'h1234);
        rd(REG_HOLD_MAP, 32'h1, 32'h7F7F);
        wr(REG_CTRL, 32'h3);
        wr(REG_EXP_OUT_BASE, 32'h4321);
        see(1'b1, 16'h4321);
        $display("test older done");
    endtask
    task automatic t_mismatch();
        attached <= 7'h05;
        cyc(6);
        rd(REG_STATUS, 32'h8, 32'h9);
        see(1'b0, 16'h0);
        wr(REG_EMB_OUT, 32'h0F0F);
        cyc(1);
        check({16'h0, o_emb_out}, 32'h0F0F, "embedded outputs");
        $display("test mismatch done");
    endtask
    // ==========
    // run control
    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        repeat (5) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        @(posedge i_mclk);
        t_regs();
        t_startup();
        t_runtime();
        t_older();
        t_mismatch();
        finish_test();
    end
endmodule // ebes_tb_top
